// ==== inc/iod_pkg.sv ====
// constants, command encodings and register masks for the io register space decoder
// Operation
// - software writes zero into reserved bit positions
// - never write a reserved io location
// - bit set/clear only at io 0x00..0x1F
// - bit test for skip in lower range
// - writing one clears flag, zero keeps
// - bit set/clear touches only the addressed bit
// - io addresses run 0x00 to 0x3F
// - data address equals io address plus 0x20
package iod_pkg;

  // ==========================================================
  // address space
  localparam int IO_NREG = 32;
  localparam logic [7:0] DATA_OFFSET = 8'h20;
  localparam logic [7:0] IO_TOP = 8'h3F;
  localparam logic [7:0] DATA_TOP = 8'h5F;
  localparam logic [7:0] BIT_TOP = 8'h1F;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic SPACE_IO = 1'b0;
  localparam logic SPACE_DATA = 1'b1;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_SET_BIT,
    OP_CLEAR_BIT,
    OP_TEST_BIT
  } iod_op_e;

  // ==========================================================
  // register offsets in io space
  localparam logic [4:0] EEPROM_ACCESS_CONTROL = 5'h1C;
  localparam logic [4:0] PORT_A_OUTPUT_LATCH = 5'h1B;
  localparam logic [4:0] PORT_A_DIRECTION = 5'h1A;
  localparam logic [4:0] PORT_A_PIN_INPUT = 5'h19;
  localparam logic [4:0] PORT_B_OUTPUT_LATCH = 5'h18;
  localparam logic [4:0] PORT_B_DIRECTION = 5'h17;
  localparam logic [4:0] PORT_B_PIN_INPUT = 5'h16;
  localparam logic [4:0] SCRATCH_REGISTER_TWO = 5'h15;
  localparam logic [4:0] SCRATCH_REGISTER_ONE = 5'h14;
  localparam logic [4:0] SCRATCH_REGISTER_ZERO = 5'h13;
  localparam logic [4:0] PORT_D_OUTPUT_LATCH = 5'h12;
  localparam logic [4:0] PORT_D_DIRECTION = 5'h11;
  localparam logic [4:0] PORT_D_PIN_INPUT = 5'h10;
  localparam logic [4:0] SERIAL_IFACE_SHIFT_DATA = 5'h0F;
  localparam logic [4:0] SERIAL_IFACE_STATUS = 5'h0E;
  localparam logic [4:0] SERIAL_IFACE_CONTROL = 5'h0D;
  localparam logic [4:0] UART_DATA_BUFFER = 5'h0C;
  localparam logic [4:0] UART_STATUS_A = 5'h0B;
  localparam logic [4:0] UART_CONTROL_B = 5'h0A;
  localparam logic [4:0] UART_BAUD_DIVISOR_LOW = 5'h09;
  localparam logic [4:0] COMPARATOR_CONTROL_STATUS = 5'h08;
  localparam logic [4:0] BROWNOUT_SLEEP_CONTROL = 5'h07;
  localparam logic [4:0] POWER_REDUCTION = 5'h06;
  localparam logic [4:0] PIN_CHANGE_MASK_TWO = 5'h05;
  localparam logic [4:0] PIN_CHANGE_MASK_ONE = 5'h04;
  localparam logic [4:0] UART_CONTROL_C = 5'h03;
  localparam logic [4:0] UART_BAUD_DIVISOR_HIGH = 5'h02;
  localparam logic [4:0] DIGITAL_INPUT_DISABLE = 5'h01;
  localparam logic [4:0] SERIAL_IFACE_BUFFER = 5'h00;

  localparam int PIN_A_W = 3;
  localparam int PIN_B_W = 8;
  localparam int PIN_D_W = 7;

  // ==========================================================
  // bit masks: plain read/write, write-one-to-clear, read-only
  function automatic logic [7:0] wr_mask(input logic [4:0] a);
    case (a)
      EEPROM_ACCESS_CONTROL: wr_mask = 8'h3F;
      PORT_A_OUTPUT_LATCH, PORT_A_DIRECTION: wr_mask = 8'h07;
      PORT_B_OUTPUT_LATCH, PORT_B_DIRECTION: wr_mask = 8'hFF;
      SCRATCH_REGISTER_TWO, SCRATCH_REGISTER_ONE, SCRATCH_REGISTER_ZERO: wr_mask = 8'hFF;
      PORT_D_OUTPUT_LATCH, PORT_D_DIRECTION: wr_mask = 8'h7F;
      SERIAL_IFACE_SHIFT_DATA, SERIAL_IFACE_CONTROL, UART_DATA_BUFFER: wr_mask = 8'hFF;
      SERIAL_IFACE_STATUS: wr_mask = 8'h0F;
      UART_STATUS_A: wr_mask = 8'h03;
      UART_CONTROL_B: wr_mask = 8'hFD;
      UART_BAUD_DIVISOR_LOW, UART_CONTROL_C: wr_mask = 8'hFF;
      COMPARATOR_CONTROL_STATUS: wr_mask = 8'hCF;
      BROWNOUT_SLEEP_CONTROL, DIGITAL_INPUT_DISABLE: wr_mask = 8'h03;
      POWER_REDUCTION, UART_BAUD_DIVISOR_HIGH: wr_mask = 8'h0F;
      PIN_CHANGE_MASK_TWO: wr_mask = 8'h7F;
      PIN_CHANGE_MASK_ONE: wr_mask = 8'h07;
      default: wr_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] w1c_mask(input logic [4:0] a);
    case (a)
      SERIAL_IFACE_STATUS: w1c_mask = 8'hE0;
      UART_STATUS_A: w1c_mask = 8'h40;
      COMPARATOR_CONTROL_STATUS: w1c_mask = 8'h10;
      default: w1c_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] ro_mask(input logic [4:0] a);
    case (a)
      PORT_A_PIN_INPUT: ro_mask = 8'h07;
      PORT_B_PIN_INPUT, SERIAL_IFACE_BUFFER: ro_mask = 8'hFF;
      PORT_D_PIN_INPUT: ro_mask = 8'h7F;
      SERIAL_IFACE_STATUS: ro_mask = 8'h10;
      UART_STATUS_A: ro_mask = 8'hBC;
      UART_CONTROL_B: ro_mask = 8'h02;
      COMPARATOR_CONTROL_STATUS: ro_mask = 8'h20;
      default: ro_mask = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // core-end control registers on apb
  localparam logic [11:0] CMD_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SPACE_BIT = 3;
  localparam int CMD_BIT_LSB = 4;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_DATA_LSB = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  localparam int ST_BITVAL = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_RDATA_LSB = 8;

endpackage

// ==== inc/iod_bus_if.sv ====
// link between processor core end and io register space end
`timescale 1ns/1ns
`default_nettype none
interface iod_bus_if;
  import iod_pkg::*;
  logic req;
  iod_op_e op;
  logic space;
  logic [7:0] addr;
  logic [2:0] bit_sel;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic bit_val;
  logic err;

  modport dev (input req, op, space, addr, bit_sel, wdata, output ack, rdata, bit_val, err);
  modport core (output req, op, space, addr, bit_sel, wdata, input ack, rdata, bit_val, err);
endinterface
`default_nettype wire

// ==== logic/iod_sync.sv ====
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module iod_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("iod_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else if (en) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ==== logic/iod_dev_end.sv ====
// io register space: address decode, bit operations and register storage
`timescale 1ns/1ns
`default_nettype none
module iod_dev_end (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  iod_bus_if.dev bus,
  input wire logic [iod_pkg::PIN_A_W-1:0] pin_a,
  input wire logic [iod_pkg::PIN_B_W-1:0] pin_b,
  input wire logic [iod_pkg::PIN_D_W-1:0] pin_d,
  input wire logic [iod_pkg::IO_NREG-1:0][7:0] hw_status,
  input wire logic [iod_pkg::IO_NREG-1:0][7:0] hw_flag_set,
  output logic [iod_pkg::IO_NREG-1:0][7:0] reg_out
);
  import iod_pkg::*;

  // ==========================================================
  // pin input synchronisers
  logic [PIN_A_W-1:0] pin_a_sync;
  logic [PIN_B_W-1:0] pin_b_sync;
  logic [PIN_D_W-1:0] pin_d_sync;

  iod_sync #(.WIDTH(PIN_A_W)) u_sync_a (
    .clk(clk),
    .rst_b(rst_b),
    .en(en),
    .async_in(pin_a),
    .sync_out(pin_a_sync)
  );
  iod_sync #(.WIDTH(PIN_B_W)) u_sync_b (
    .clk(clk),
    .rst_b(rst_b),
    .en(en),
    .async_in(pin_b),
    .sync_out(pin_b_sync)
  );
  iod_sync #(.WIDTH(PIN_D_W)) u_sync_d (
    .clk(clk),
    .rst_b(rst_b),
    .en(en),
    .async_in(pin_d),
    .sync_out(pin_d_sync)
  );

  // ==========================================================
  // address decode
  logic ack_reg;
  logic [7:0] rdata_reg;
  logic bit_val_reg;
  logic err_reg;

  wire from_data = bus.space == SPACE_DATA;
  wire data_in_range = (bus.addr >= DATA_OFFSET) && (bus.addr <= DATA_TOP);
  wire io_in_range = bus.addr <= IO_TOP;
  wire in_range = from_data ? data_in_range : io_in_range;
  wire [7:0] io_addr = from_data ? 8'(bus.addr - DATA_OFFSET) : bus.addr;
  wire lower = in_range && (io_addr <= BIT_TOP);
  wire [4:0] idx = io_addr[4:0];
  wire is_write = bus.op == OP_WRITE;
  wire is_set = bus.op == OP_SET_BIT;
  wire is_clear = bus.op == OP_CLEAR_BIT;
  wire is_test = bus.op == OP_TEST_BIT;
  wire is_bit_op = is_set || is_clear || is_test;
  wire bad_op = !(bus.op inside {OP_READ, OP_WRITE, OP_SET_BIT, OP_CLEAR_BIT, OP_TEST_BIT});
  wire refused = !in_range || bad_op || (is_bit_op && !lower);
  wire take = en && bus.req && !ack_reg;
  wire modify = take && !refused && lower && (is_write || is_set || is_clear);
  wire [7:0] bit_mask = 8'(8'h01 << bus.bit_sel);

  // ==========================================================
  // register storage, one entry per io address below 0x20
  logic [IO_NREG-1:0][7:0] read_view;

  for (genvar i = 0; i < IO_NREG; i++) begin : g_reg
    localparam logic [7:0] WM = wr_mask(5'(i));
    localparam logic [7:0] W1 = w1c_mask(5'(i));
    localparam logic [7:0] RO = ro_mask(5'(i));
    logic [7:0] val_reg;
    logic [7:0] val_next;
    logic [7:0] src;
    wire hit = modify && (idx == 5'(i));
    // a bit operation narrows the write and write-one-to-clear masks to the addressed bit
    wire [7:0] eff_wm = is_write ? WM : (WM & bit_mask);
    wire [7:0] eff_w1 = is_write ? W1 : (W1 & bit_mask);
    wire [7:0] wd = is_write ? bus.wdata : (is_set ? bit_mask : 8'h00);
    wire [7:0] written = ((val_reg & ~eff_wm) | (wd & eff_wm)) & ~(wd & eff_w1);

    // hardware flag set beats a clear in the same cycle
    assign val_next = ((hit ? written : val_reg) | (hw_flag_set[i] & W1)) & (WM | W1);

    assign src = (5'(i) == PORT_A_PIN_INPUT) ? 8'(pin_a_sync) :
                 (5'(i) == PORT_B_PIN_INPUT) ? 8'(pin_b_sync) :
                 (5'(i) == PORT_D_PIN_INPUT) ? 8'(pin_d_sync) : hw_status[i];
    // reserved bits and unmapped addresses read zero
    assign read_view[i] = (val_reg & (WM | W1)) | (src & RO);
    assign reg_out[i] = val_reg;

    always_ff @(posedge clk) begin
      if (!rst_b) begin
        val_reg <= RESET_VALUE;
      end else if (en) begin
        val_reg <= val_next;
      end
    end
  end

  // ==========================================================
  // response
  // upper half of io space is unmapped here: reads zero, writes dropped
  wire [7:0] rdata_next = (!refused && lower) ? read_view[idx] : 8'h00;
  wire bit_val_next = is_test && !refused && rdata_next[bus.bit_sel];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
      bit_val_reg <= 1'b0;
      err_reg <= 1'b0;
    end else if (en) begin
      ack_reg <= take;
      if (take) begin
        rdata_reg <= rdata_next;
        bit_val_reg <= bit_val_next;
        err_reg <= refused;
      end
    end
  end

  assign bus.ack = ack_reg;
  assign bus.rdata = rdata_reg;
  assign bus.bit_val = bit_val_reg;
  assign bus.err = err_reg;
endmodule
`default_nettype wire

// ==== logic/iod_core_end.sv ====
// processor core end: takes io access orders over apb and issues them on the link
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module iod_core_end (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  iod_bus_if.core bus
);
  import iod_pkg::*;

  typedef enum logic {S_IDLE, S_WAIT} iod_state_e;

  // ==========================================================
  // apb decode
  iod_state_e state_reg;
  logic done_reg;
  logic err_reg;
  logic bit_val_reg;
  logic overrun_reg;
  logic [7:0] rdata_reg;
  logic [31:0] cmd_reg;
  logic [31:0] prdata_reg;

  wire hit_cmd = paddr == CMD_OFF;
  wire hit_status = paddr == STATUS_OFF;
  wire mapped = hit_cmd || hit_status;
  wire access = en && psel && penable;
  wire wr_cmd = access && pwrite && hit_cmd;
  wire wr_status = access && pwrite && hit_status;
  wire busy = state_reg == S_WAIT;

  wire [31:0] status_word = {16'h0000, rdata_reg, 3'b000, overrun_reg, bit_val_reg,
                             err_reg, done_reg, busy};
  wire [31:0] read_word = hit_cmd ? cmd_reg : (hit_status ? status_word : 32'h0000_0000);

  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;

  // ==========================================================
  // command fields
  iod_op_e new_op;
  assign new_op = iod_op_e'(pwdata[CMD_OP_LSB +: 3]);
  wire new_space = pwdata[CMD_SPACE_BIT];
  wire [7:0] new_addr = pwdata[CMD_ADDR_LSB +: 8];
  wire [7:0] new_data = pwdata[CMD_DATA_LSB +: 8];
  wire [7:0] new_io = (new_space == SPACE_DATA) ? 8'(new_addr - DATA_OFFSET) : new_addr;
  wire new_in_range = (new_space == SPACE_DATA) ?
                      ((new_addr >= DATA_OFFSET) && (new_addr <= DATA_TOP)) :
                      (new_addr <= IO_TOP);
  wire new_lower = new_in_range && (new_io <= BIT_TOP);
  wire [7:0] new_live = wr_mask(new_io[4:0]) | w1c_mask(new_io[4:0]);
  wire new_writes = new_op inside {OP_WRITE, OP_SET_BIT, OP_CLEAR_BIT};
  // writes to locations with no writable bit are never put on the link
  wire new_reserved = new_writes && (!new_lower || (new_live == 8'h00));
  wire launch = wr_cmd && !busy && !new_reserved;
  wire refuse_local = wr_cmd && !busy && new_reserved;

  // ==========================================================
  // sequencer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= S_IDLE;
      bus.req <= 1'b0;
      bus.op <= OP_READ;
      bus.space <= SPACE_IO;
      bus.addr <= 8'h00;
      bus.bit_sel <= 3'h0;
      bus.wdata <= 8'h00;
    end else if (en) begin
      case (state_reg)
        S_IDLE: begin
          if (launch) begin
            state_reg <= S_WAIT;
            bus.req <= 1'b1;
            bus.op <= new_op;
            bus.space <= new_space;
            bus.addr <= new_addr;
            bus.bit_sel <= pwdata[CMD_BIT_LSB +: 3];
            bus.wdata <= (new_op == OP_WRITE) ? (new_data & new_live) : new_data;
          end
        end
        S_WAIT: begin
          if (bus.ack) begin
            state_reg <= S_IDLE;
            bus.req <= 1'b0;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // status and apb data
  wire fin = busy && bus.ack;
  wire clr_done = wr_status && pwdata[ST_DONE];
  wire clr_over = wr_status && pwdata[ST_OVERRUN];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmd_reg <= 32'h0000_0000;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      bit_val_reg <= 1'b0;
      overrun_reg <= 1'b0;
      rdata_reg <= 8'h00;
      prdata_reg <= 32'h0000_0000;
    end else if (en) begin
      if (wr_cmd && !busy) begin
        cmd_reg <= pwdata;
      end
      done_reg <= fin || refuse_local || (done_reg && !clr_done);
      overrun_reg <= (wr_cmd && busy) || (overrun_reg && !clr_over);
      if (fin) begin
        err_reg <= bus.err;
        bit_val_reg <= bus.bit_val;
        rdata_reg <= bus.rdata;
      end else if (refuse_local) begin
        err_reg <= 1'b1;
        bit_val_reg <= 1'b0;
        rdata_reg <= 8'h00;
      end
      if (psel && !penable) begin
        prdata_reg <= read_word;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/iod_link_monitor.sv ====
// concurrent checks on the link between the core end and the register space end
`timescale 1ns/1ns
`default_nettype none
module iod_link_monitor
  import iod_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req,
  input wire iod_pkg::iod_op_e op,
  input wire logic space,
  input wire logic [7:0] addr,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic bit_val,
  input wire logic err
);
  // ==========
  // decode helpers
  logic [7:0] io_a;
  logic in_rng;
  logic bit_op;
  assign io_a = space ? addr - DATA_OFFSET : addr;
  assign in_rng = space ? (addr >= DATA_OFFSET && addr <= DATA_TOP) : (addr <= IO_TOP);
  assign bit_op = op inside {OP_SET_BIT, OP_CLEAR_BIT, OP_TEST_BIT};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_take;
    req && !ack;
  endsequence
  sequence s_refuse;
    ack && err && rdata == 8'h00 && !bit_val;
  endsequence

  // ==========
  // checks
  chk_answer_timing:
    assert property (s_take |=> ack) else $error("link answer not one cycle after request");
  chk_ack_single:
    assert property (ack |=> !ack && !req) else $error("ack longer than one cycle");
  chk_range_refused:
    assert property ((s_take and !in_rng) |=> s_refuse) else $error("out of range not refused");
  chk_upper_bitop:
    assert property ((s_take and (in_rng && bit_op && io_a > BIT_TOP)) |=> s_refuse)
      else $error("bit operation above lower range not refused");
  chk_reserved_zero:
    assert property ((s_take and (in_rng && op == OP_READ && io_a > 8'h1C)) |=>
                     ack && !err && rdata == 8'h00)
      else $error("reserved read not zero");
  chk_skip_bit:
    assert property (ack && !err && $past(op) == OP_TEST_BIT |-> bit_val == rdata[$past(bit_sel)])
      else $error("tested bit disagrees with register value");
  chk_skip_other:
    assert property (ack && $past(op) != OP_TEST_BIT |-> !bit_val) else $error("bit_val without test");
  chk_answer_holds:
    assert property (!ack |-> $stable(rdata) && $stable(err) && $stable(bit_val))
      else $error("answer changed without ack");
  chk_req_holds:
    assert property (s_take |=> $stable(addr) && $stable(space) && $stable(op))
      else $error("request fields changed before ack");
endmodule
`default_nettype wire

// ==== verification/io_register_space_decoder_test.sv ====
// self-checking bench: core end and register space end joined by the link
`timescale 1ns/1ns
`default_nettype none
module io_register_space_decoder_test;
  import iod_pkg::*;
  // ==========
  // one access and the status it should leave
  typedef struct {
    iod_op_e op;
    logic sp;
    logic [7:0] a;
    logic [2:0] b;
    logic [7:0] wd;
    logic ck;
    logic [7:0] rd;
    logic er;
    logic bv;
  } iod_row_s;
  logic clk;
  logic rst_b;
  logic en;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [PIN_A_W-1:0] pin_a;
  logic [PIN_B_W-1:0] pin_b;
  logic [PIN_D_W-1:0] pin_d;
  logic [IO_NREG-1:0][7:0] hw_status;
  logic [IO_NREG-1:0][7:0] hw_flag_set;
  logic [IO_NREG-1:0][7:0] reg_out;
  logic [31:0] q;
  logic e;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  iod_row_s rows [18] = '{
    '{OP_WRITE, 1'b0, 8'h17, 3'h0, 8'hA5, 1'b0, 8'h00, 1'b0, 1'b0},
    '{OP_READ, 1'b1, 8'h37, 3'h0, 8'h00, 1'b1, 8'hA5, 1'b0, 1'b0},
    '{OP_SET_BIT, 1'b0, 8'h17, 3'h1, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0},
    '{OP_READ, 1'b0, 8'h17, 3'h0, 8'h00, 1'b1, 8'hA7, 1'b0, 1'b0},
    '{OP_CLEAR_BIT, 1'b1, 8'h37, 3'h7, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0},
    '{OP_TEST_BIT, 1'b0, 8'h17, 3'h5, 8'h00, 1'b1, 8'h27, 1'b0, 1'b1},
    '{OP_TEST_BIT, 1'b1, 8'h37, 3'h3, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0},
    '{OP_WRITE, 1'b0, 8'h1B, 3'h0, 8'hFF, 1'b0, 8'h00, 1'b0, 1'b0},
    '{OP_READ, 1'b0, 8'h1B, 3'h0, 8'h00, 1'b1, 8'h07, 1'b0, 1'b0},
    '{OP_READ, 1'b0, 8'h16, 3'h0, 8'h00, 1'b1, 8'h3C, 1'b0, 1'b0},
    '{OP_READ, 1'b1, 8'h39, 3'h0, 8'h00, 1'b1, 8'h05, 1'b0, 1'b0},
    '{OP_READ, 1'b0, 8'h08, 3'h0, 8'h00, 1'b1, 8'h20, 1'b0, 1'b0},
    '{OP_READ, 1'b0, 8'h1F, 3'h0, 8'h00, 1'b1, 8'h00, 1'b0, 1'b0},
    '{OP_READ, 1'b0, 8'h25, 3'h0, 8'h00, 1'b1, 8'h00, 1'b0, 1'b0},
    '{OP_TEST_BIT, 1'b0, 8'h20, 3'h0, 8'h00, 1'b1, 8'h00, 1'b1, 1'b0},
    '{OP_READ, 1'b1, 8'h1F, 3'h0, 8'h00, 1'b1, 8'h00, 1'b1, 1'b0},
    '{OP_WRITE, 1'b0, 8'h10, 3'h0, 8'hFF, 1'b0, 8'h00, 1'b1, 1'b0},
    '{OP_READ, 1'b0, 8'h10, 3'h0, 8'h00, 1'b1, 8'h2A, 1'b0, 1'b0}};
  iod_row_s flg [8] = '{
    '{OP_SET_BIT, 1'b0, 8'h0E, 3'h6, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0},
    '{OP_READ, 1'b1, 8'h2E, 3'h0, 8'h00, 1'b1, 8'hA0, 1'b0, 1'b0},
    '{OP_CLEAR_BIT, 1'b0, 8'h0E, 3'h7, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0},
    '{OP_READ, 1'b0, 8'h0E, 3'h0, 8'h00, 1'b1, 8'hA0, 1'b0, 1'b0},
    '{OP_WRITE, 1'b0, 8'h0E, 3'h0, 8'h20, 1'b0, 8'h00, 1'b0, 1'b0},
    '{OP_READ, 1'b0, 8'h0E, 3'h0, 8'h00, 1'b1, 8'h80, 1'b0, 1'b0},
    '{OP_WRITE, 1'b0, 8'h0E, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0},
    '{OP_READ, 1'b0, 8'h0E, 3'h0, 8'h00, 1'b1, 8'h80, 1'b0, 1'b0}};

  // ==========
  // both ends and the link
  iod_bus_if iod_bus_if_i ();
  iod_core_end iod_core_end_i (.clk(clk), .rst_b(rst_b), .en(en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(iod_bus_if_i));
  iod_dev_end iod_dev_end_i (.clk(clk), .rst_b(rst_b), .en(en), .bus(iod_bus_if_i),
    .pin_a(pin_a), .pin_b(pin_b), .pin_d(pin_d), .hw_status(hw_status),
    .hw_flag_set(hw_flag_set), .reg_out(reg_out));
  iod_link_monitor iod_link_monitor_i (.clk(clk), .rst_b(rst_b), .req(iod_bus_if_i.req),
    .op(iod_bus_if_i.op), .space(iod_bus_if_i.space), .addr(iod_bus_if_i.addr),
    .bit_sel(iod_bus_if_i.bit_sel), .wdata(iod_bus_if_i.wdata), .ack(iod_bus_if_i.ack),
    .rdata(iod_bus_if_i.rdata), .bit_val(iod_bus_if_i.bit_val), .err(iod_bus_if_i.err));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========
  // tasks
  task automatic chk_val(input string nm, input logic [7:0] x, input logic [7:0] g);
    samples_checked++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", nm, x, g);
      bad_count++;
    end
  endtask
  task automatic chk_bit(input string nm, input logic x, input logic g);
    samples_checked++;
    if (g !== x) begin
      $display("[ERR] %s expected %b seen %b", nm, x, g);
      bad_count++;
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic run_row(input iod_row_s r);
    logic [31:0] st;
    logic [31:0] rq;
    logic re;
    int n;
    n = 0;
    apb(1'b1, CMD_OFF, {8'h00, r.wd, r.a, 1'b0, r.b, r.sp, r.op}, rq, re);
    do begin
      apb(1'b0, STATUS_OFF, 32'h0000_0000, st, re);
      n++;
    end while (st[ST_DONE] !== 1'b1 && n < 20);
    chk_bit("done", 1'b1, st[ST_DONE]);
    chk_bit("busy", 1'b0, st[ST_BUSY]);
    apb(1'b1, STATUS_OFF, 32'h0000_0012, rq, re);
    chk_bit("err", r.er, st[ST_ERR]);
    chk_bit("skip", r.bv, st[ST_BITVAL]);
    if (r.ck) chk_val("rdata", r.rd, st[ST_RDATA_LSB +: 8]);
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
  end

  // ==========
  // main sequence
  initial begin
    rst_b = 1'b0;
    en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pin_a = 3'h5;
    pin_b = 8'h3C;
    pin_d = 7'h2A;
    hw_status = '0;
    hw_status[COMPARATOR_CONTROL_STATUS] = 8'hFF;
    hw_flag_set = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) run_row(rows[i]);
    // three flags raised together
    hw_flag_set[SERIAL_IFACE_STATUS] <= 8'hE0;
    @(posedge clk);
    hw_flag_set[SERIAL_IFACE_STATUS] <= 8'h00;
    @(posedge clk);
    foreach (flg[i]) run_row(flg[i]);
    chk_val("flags", 8'h80, reg_out[SERIAL_IFACE_STATUS]);
    apb(1'b0, 12'h008, 32'h0000_0000, q, e);
    chk_bit("pslverr", 1'b1, e);
    chk_val("prdata", 8'h00, q[7:0]);
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk_val("reg_out", 8'h00, reg_out[PORT_B_DIRECTION]);
    run_row('{OP_READ, 1'b1, 8'h37, 3'h0, 8'h00, 1'b1, 8'h00, 1'b0, 1'b0});
    apb(1'b0, CMD_OFF, 32'h0000_0000, q, e);
    chk_bit("cmd_pslverr", 1'b0, e);
    chk_val("cmd_addr", 8'h37, q[15:8]);
    end_of_test();
  end
endmodule
`default_nettype wire
